// File: hdl/getot_top.sv
// Purpose: Four gated edge totalizer channels behind AXI4-Lite
// Assumes: Comparators outside; both thresholds feed per-channel inputs
// Notes: Channel n at CNT_BASE+4n, config at CFG_BASE+4n
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module getot_top
  import getot_pkg::*;
#(
  parameter int unsigned NCH = GETOT_NCH,
  parameter int unsigned CW = GETOT_CW
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire getot_axi_req_t axi_req,
  output getot_axi_rsp_t axi_rsp,
  input wire logic [NCH-1:0] cmp_zero,
  input wire logic [NCH-1:0] cmp_ttl,
  input wire logic [NCH-1:0] gate_pos,
  input wire logic [NCH-1:0] gate_neg,
  input wire logic scan_req,
  output logic scan_done,
  output logic [CW-1:0] scan_data,
  output logic tot_power
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NCH-1:0][CW-1:0] cnt;
    getot_cfg_t [NCH-1:0] cfg;
    logic [NCH-1:0] in_prev;
    logic pwr;
    logic [1:0] scan_ch;
    getot_scan_t sc;
    logic [CW-1:0] scan_buf;
    logic scan_done;
    logic aw_hold;
    logic [GETOT_AW-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } getot_st_t;
  getot_st_t st_q, st_d;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [NCH-1:0] zero_s, ttl_s, gp_s, gn_s;

  getot_sync #(.W(NCH), .RST_VAL('0)) u_sync_zero (
    .ref_clk(ref_clk), .srst(srst), .din(cmp_zero), .dout(zero_s));
  getot_sync #(.W(NCH), .RST_VAL('0)) u_sync_ttl (
    .ref_clk(ref_clk), .srst(srst), .din(cmp_ttl), .dout(ttl_s));
  // Reset values match the permissive bias of open gates
  getot_sync #(.W(NCH), .RST_VAL('1)) u_sync_gp (
    .ref_clk(ref_clk), .srst(srst), .din(gate_pos), .dout(gp_s));
  getot_sync #(.W(NCH), .RST_VAL('0)) u_sync_gn (
    .ref_clk(ref_clk), .srst(srst), .din(gate_neg), .dout(gn_s));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_cnt(input logic [GETOT_AW-1:0] a);
    return a[7:4] == GETOT_CNT_BASE[7:4];
  endfunction

  function automatic logic is_cfg(input logic [GETOT_AW-1:0] a);
    return a[7:4] == GETOT_CFG_BASE[7:4];
  endfunction

  function automatic logic [1:0] ch_of(input logic [GETOT_AW-1:0] a);
    return a[3:2];
  endfunction

  function automatic logic sel_lvl(input getot_cfg_t c, input logic z, input logic t);
    return c.thr_ttl ? t : z;
  endfunction

  function automatic logic edge_hit(input getot_cfg_t c, input logic prev, input logic cur);
    return c.edge_fall ? (prev & ~cur) : (~prev & cur);
  endfunction

  function automatic getot_cfg_t cfg_unpack(input logic [31:0] d);
    getot_cfg_t c;
    c.edge_fall = d[GETOT_CFG_EDGE_BIT];
    c.thr_ttl = d[GETOT_CFG_THR_BIT];
    c.rd_clr = d[GETOT_CFG_RDCLR_BIT];
    return c;
  endfunction

  function automatic logic [31:0] cfg_pack(input getot_cfg_t c);
    logic [31:0] d;
    d = GETOT_ZERO;
    d[GETOT_CFG_EDGE_BIT] = c.edge_fall;
    d[GETOT_CFG_THR_BIT] = c.thr_ttl;
    d[GETOT_CFG_RDCLR_BIT] = c.rd_clr;
    return d;
  endfunction

  logic [NCH-1:0] in_sel;
  logic [NCH-1:0] hit;
  logic wr_go, rd_go;
  logic [GETOT_AW-1:0] wa;
  logic [31:0] wd;
  getot_cfg_t ncfg;
  logic [NCH-1:0] gate_ok;
  logic [GETOT_AW-1:0] ra;
  logic [1:0] wch;
  logic [1:0] rch;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // Threshold select picks the comparator output
      in_sel[i] = sel_lvl(st_q.cfg[i], zero_s[i], ttl_s[i]);
      gate_ok[i] = gp_s[i] & ~gn_s[i];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    ncfg = '0;
    wa = st_q.aw_hold ? st_q.aw_addr : axi_req.awaddr;
    wd = st_q.w_hold ? st_q.w_data : axi_req.wdata;
    ra = axi_req.araddr;
    wch = ch_of(wa);
    rch = ch_of(ra);
    wr_go = (st_q.aw_hold | axi_req.awvalid) & (st_q.w_hold | axi_req.wvalid) &
      ~st_q.bvalid;
    rd_go = axi_req.arvalid & ~st_q.rvalid;
    st_d.in_prev = in_sel;
    st_d.scan_done = 1'b0;

    // ----------------------------------------
    // Edge detection, gate sampled with the edge
    // ----------------------------------------
    for (int i = 0; i < NCH; i++) begin
      hit[i] = edge_hit(st_q.cfg[i], st_q.in_prev[i], in_sel[i])
        & gate_ok[i]
        & st_q.pwr;
      if (hit[i]) begin
        st_d.cnt[i] = st_q.cnt[i] + CW'(GETOT_ONE);
      end
    end

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    // Same-cycle bus write wins over an increment
    if (~st_q.aw_hold & axi_req.awvalid & ~wr_go) begin
      st_d.aw_hold = 1'b1;
      st_d.aw_addr = axi_req.awaddr;
    end
    if (~st_q.w_hold & axi_req.wvalid & ~wr_go) begin
      st_d.w_hold = 1'b1;
      st_d.w_data = axi_req.wdata;
    end
    if (wr_go) begin
      st_d.aw_hold = 1'b0;
      st_d.w_hold = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = GETOT_RESP_OK;
      if (is_cnt(wa)) begin
        // Zero clears, nonzero presets; config untouched
        st_d.cnt[wch] = wd[CW-1:0];
      end else if (is_cfg(wa)) begin
        ncfg = cfg_unpack(wd);
        st_d.cfg[wch] = ncfg;
        if ((ncfg.edge_fall != st_q.cfg[wch].edge_fall) ||
            (ncfg.thr_ttl != st_q.cfg[wch].thr_ttl)) begin
          st_d.cnt[wch] = '0;
          // Edge history restarts at the new level, so no false count
          st_d.in_prev[wch] = sel_lvl(ncfg, zero_s[wch], ttl_s[wch]);
        end
      end else if (wa == GETOT_PWR_OFF) begin
        st_d.pwr = wd[0];
      end else if (wa == GETOT_SCAN_OFF) begin
        st_d.scan_ch = wd[1:0];
      end else begin
        st_d.bresp = GETOT_RESP_SLVERR;
      end
    end
    if (st_q.bvalid & axi_req.bready) begin
      st_d.bvalid = 1'b0;
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    if (rd_go) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = GETOT_RESP_OK;
      st_d.rdata = GETOT_ZERO;
      if (is_cnt(ra)) begin
        st_d.rdata[CW-1:0] = st_q.cnt[rch];
        if (st_q.cfg[rch].rd_clr) begin
          st_d.cnt[rch] = '0;
        end
      end else if (is_cfg(ra)) begin
        st_d.rdata = cfg_pack(st_q.cfg[rch]);
      end else if (ra == GETOT_PWR_OFF) begin
        st_d.rdata[0] = st_q.pwr;
      end else if (ra == GETOT_STAT_OFF) begin
        st_d.rdata[NCH-1:0] = in_sel;
        st_d.rdata[2*NCH-1:NCH] = gate_ok;
      end else if (ra == GETOT_SCAN_OFF) begin
        st_d.rdata[1:0] = st_q.scan_ch;
      end else if (ra == GETOT_SRES_OFF) begin
        st_d.rdata[CW-1:0] = st_q.scan_buf;
      end else begin
        st_d.rresp = GETOT_RESP_SLVERR;
      end
    end
    if (st_q.rvalid & axi_req.rready) begin
      st_d.rvalid = 1'b0;
    end

    // ----------------------------------------
    // Scan capture of the full count
    // ----------------------------------------
    case (st_q.sc)
      GETOT_SC_IDLE: begin
        if (scan_req) begin
          st_d.sc = GETOT_SC_CAPT;
        end
      end
      GETOT_SC_CAPT: begin
        st_d.scan_buf = st_q.cnt[st_q.scan_ch];
        st_d.scan_done = 1'b1;
        st_d.sc = GETOT_SC_DONE;
      end
      GETOT_SC_DONE: begin
        if (~scan_req) begin
          st_d.sc = GETOT_SC_IDLE;
        end
      end
      default: begin
        st_d.sc = GETOT_SC_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // Power-on defaults: rising edge, logic threshold, power on
      st_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        st_q.cfg[i] <= getot_cfg_t'(GETOT_CFG_RST);
      end
      st_q.pwr <= GETOT_PWR_RST;
      st_q.sc <= GETOT_SC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    // Ready while nothing is held and no answer waits
    axi_rsp = '0;
    axi_rsp.awready = ~st_q.aw_hold & ~st_q.bvalid;
    axi_rsp.wready = ~st_q.w_hold & ~st_q.bvalid;
    axi_rsp.bvalid = st_q.bvalid;
    axi_rsp.bresp = st_q.bresp;
    axi_rsp.arready = ~st_q.rvalid;
    axi_rsp.rvalid = st_q.rvalid;
    axi_rsp.rdata = st_q.rdata;
    axi_rsp.rresp = st_q.rresp;
  end

  assign scan_done = st_q.scan_done;
  assign scan_data = st_q.scan_buf;
  assign tot_power = st_q.pwr;
endmodule

// File: inc/getot_pkg.sv
// Purpose: Shared constants and types for the gated edge totalizer
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Register offsets are byte addresses
package getot_pkg;
  localparam int unsigned GETOT_NCH = 4;
  localparam int unsigned GETOT_CW = 32;
  localparam int unsigned GETOT_AW = 8;
  localparam int unsigned GETOT_FIRST_CH = 6;
  // Register byte offsets
  localparam logic [7:0] GETOT_CNT_BASE = 8'h00;
  localparam logic [7:0] GETOT_CFG_BASE = 8'h10;
  localparam logic [7:0] GETOT_PWR_OFF = 8'h20;
  localparam logic [7:0] GETOT_STAT_OFF = 8'h24;
  localparam logic [7:0] GETOT_SCAN_OFF = 8'h28;
  localparam logic [7:0] GETOT_SRES_OFF = 8'h2c;
  // Config fields
  localparam int unsigned GETOT_CFG_EDGE_BIT = 0;
  localparam int unsigned GETOT_CFG_THR_BIT = 1;
  localparam int unsigned GETOT_CFG_RDCLR_BIT = 2;
  localparam logic [2:0] GETOT_CFG_RST = 3'h2;
  localparam logic GETOT_EDGE_RISE = 1'b0;
  localparam logic GETOT_THR_TTL = 1'b1;
  localparam logic GETOT_PWR_RST = 1'b1;
  localparam logic [1:0] GETOT_RESP_OK = 2'h0;
  localparam logic [1:0] GETOT_RESP_SLVERR = 2'h2;
  localparam logic [31:0] GETOT_ZERO = 32'h0000_0000;
  localparam logic [31:0] GETOT_ONE = 32'h0000_0001;

  typedef struct packed {
    logic edge_fall;
    logic thr_ttl;
    logic rd_clr;
  } getot_cfg_t;

  typedef struct packed {
    logic awvalid;
    logic [GETOT_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [GETOT_AW-1:0] araddr;
    logic rready;
  } getot_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } getot_axi_rsp_t;

  typedef enum logic [1:0] {
    GETOT_SC_IDLE = 2'b00,
    GETOT_SC_CAPT = 2'b01,
    GETOT_SC_DONE = 2'b10
  } getot_scan_t;
endpackage

// File: hdl/getot_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to ref_clk
// Notes: A change is taken once stages two and three agree
`timescale 1ns/100ps
module getot_sync
  import getot_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } getot_sy_t;
  getot_sy_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.o[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, o: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.o;
endmodule

// File: verif/getot_monitor.sv
// Purpose: Port checks for getot_top
// Assumes: Bound to every getot_top
// Notes: One clock domain
`timescale 1ns/100ps
module getot_monitor
  import getot_pkg::*;
#(
  parameter int unsigned NCH = 4,
  parameter int unsigned CW = 32
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire getot_axi_req_t axi_req,
  input wire getot_axi_rsp_t axi_rsp,
  input wire logic scan_req,
  input wire logic scan_done,
  input wire logic [CW-1:0] scan_data,
  input wire logic tot_power
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_b_stands: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("bvalid dropped");
  a_r_stands: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("rdata moved");
  a_b_follows: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |=> axi_rsp.bvalid) else $error("no bvalid");
  a_r_follows: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid) else $error("no rvalid");
  a_ar_refused: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("arready with rvalid");
  a_w_refused: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("awready with bvalid");
  a_scan_pulse: assert property (scan_done |=> !scan_done) else $error("long done");
  a_scan_cause: assert property (scan_done |-> $past(scan_req, 2))
    else $error("done without request");
  a_scan_hold: assert property ($changed(scan_data) |-> scan_done)
    else $error("scan data moved");
  a_pwr_reset: assert property (disable iff (1'b0) srst |=> tot_power)
    else $error("power off after reset");
endmodule
bind getot_top getot_monitor #(.NCH(NCH), .CW(CW)) u_mon (.ref_clk(ref_clk),
  .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp), .scan_req(scan_req),
  .scan_done(scan_done), .scan_data(scan_data), .tot_power(tot_power));

// File: verif/getot_src.sv
// Purpose: Pulse source and gate driver model
// Assumes: Tasks called by the bench
// Notes: TTL crossing also crosses 0 V
`timescale 1ns/100ps
module getot_src
  import getot_pkg::*;
(
  input wire logic ref_clk,
  output logic [3:0] cmp_zero,
  output logic [3:0] cmp_ttl,
  output logic [3:0] gate_pos,
  output logic [3:0] gate_neg
);
  // Unwired gates rest at permissive bias
  initial begin
    cmp_zero = '0;
    cmp_ttl = '0;
    gate_pos = '1;
    gate_neg = '0;
  end
  task automatic gate(input logic [3:0] p, input logic [3:0] n);
    @(posedge ref_clk);
    gate_pos <= p;
    gate_neg <= n;
    repeat (4) @(posedge ref_clk); // Settle before next edge
  endtask
  task automatic pulse(input logic [3:0] m, input logic t, input int k);
    repeat (k) begin
      @(posedge ref_clk);
      cmp_zero <= cmp_zero | m;
      if (t) cmp_ttl <= cmp_ttl | m;
      repeat (6) @(posedge ref_clk);
      cmp_zero <= cmp_zero & ~m;
      cmp_ttl <= cmp_ttl & ~m;
      repeat (6) @(posedge ref_clk);
    end
  endtask
endmodule

// File: verif/test_gated_edge_totalizer.sv
// Purpose: Self-checking bench for getot_top
// Assumes: 250 MHz clock, AXI4-Lite master tasks
// Notes: One task per scenario
`timescale 1ns/100ps
module test_gated_edge_totalizer
  import getot_pkg::*;
;
  logic ref_clk = 0, srst = 1, scan_req = 0, scan_done, tot_power;
  getot_axi_req_t rq = '0;
  getot_axi_rsp_t rs;
  logic [3:0] cz, ct, gp, gn;
  logic [31:0] scan_data, rdv;
  logic [1:0] rr;
  int err_count = 0, n_tests = 0;
  getot_src src(.ref_clk(ref_clk), .cmp_zero(cz), .cmp_ttl(ct), .gate_pos(gp),
    .gate_neg(gn));
  getot_top dut(.ref_clk(ref_clk), .srst(srst), .axi_req(rq), .axi_rsp(rs),
    .cmp_zero(cz), .cmp_ttl(ct), .gate_pos(gp), .gate_neg(gn), .scan_req(scan_req),
    .scan_done(scan_done), .scan_data(scan_data), .tot_power(tot_power));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------
  // Bus tasks
  // ----------
  task stop_test;
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    rq.awvalid <= 1;
    rq.awaddr <= a;
    rq.wvalid <= 1;
    rq.wdata <= d;
    rq.wstrb <= 4'hf;
    rq.bready <= 1;
    forever begin
      @(posedge ref_clk);
      if (rs.awready) rq.awvalid <= 0;
      if (rs.wready) rq.wvalid <= 0;
      if (rs.bvalid) break;
    end
    rr = rs.bresp;
    rq.bready <= 0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    rq.arvalid <= 1;
    rq.araddr <= a;
    rq.rready <= 1;
    forever begin
      @(posedge ref_clk);
      if (rs.arready) rq.arvalid <= 0;
      if (rs.rvalid) break;
    end
    rdv = rs.rdata;
    rr = rs.rresp;
    rq.rready <= 0;
    chk(rdv, e);
  endtask
  function automatic logic [7:0] cnt(int i);
    return GETOT_CNT_BASE + 8'(4 * i);
  endfunction
  function automatic logic [7:0] cfg(int i);
    return GETOT_CFG_BASE + 8'(4 * i);
  endfunction
  task t_reset;
    for (int i = 0; i < 4; i++) begin
      rdc(cfg(i), {29'h0, GETOT_CFG_RST});
      rdc(cnt(i), 32'h0);
    end
    rdc(GETOT_PWR_OFF, 32'h1);
    rdc(GETOT_STAT_OFF, 32'h0000_00f0);
  endtask
  task t_count;
    for (int i = 0; i < 4; i++) begin
      src.pulse(4'(1 << i), 1, i + 1);
      for (int j = 0; j < 4; j++) rdc(cnt(j), j <= i ? 32'(j + 1) : 32'h0);
    end
    rdc(cnt(3), 32'h4);
  endtask
  task t_edge;
    wr(cfg(0), 32'h3);
    rdc(cnt(0), 32'h0);
    src.pulse(4'h1, 1, 2);
    rdc(cnt(0), 32'h2);
    wr(cfg(0), 32'h1);
    rdc(cnt(0), 32'h0);
    src.pulse(4'h1, 0, 3);
    rdc(cnt(0), 32'h3);
    wr(cfg(0), 32'h2);
    src.pulse(4'h1, 0, 2);
    rdc(cnt(0), 32'h0);
  endtask
  task t_wr;
    wr(cnt(1), 32'h0);
    rdc(cnt(1), 32'h0);
    rdc(cfg(1), 32'h2);
    wr(cnt(1), 32'hffff_ffff);
    rdc(cnt(1), 32'hffff_ffff);
    src.pulse(4'h2, 1, 2);
    rdc(cnt(1), 32'h1);
  endtask
  task t_rdclr;
    wr(cfg(2), 32'h6);
    src.pulse(4'h4, 1, 2);
    rdc(cnt(2), 32'h5);
    rdc(cnt(2), 32'h0);
  endtask
  task t_gate;
    src.gate(4'he, 4'h0);
    src.pulse(4'h1, 1, 1);
    rdc(cnt(0), 32'h0);
    src.gate(4'hf, 4'h1);
    src.pulse(4'h1, 1, 1);
    rdc(cnt(0), 32'h0);
    src.gate(4'hf, 4'h0);
    src.pulse(4'h1, 1, 1);
    rdc(cnt(0), 32'h1);
  endtask
  task t_pwr;
    wr(GETOT_PWR_OFF, 32'h0);
    chk({31'h0, tot_power}, 32'h0);
    src.pulse(4'h8, 1, 1);
    rdc(cnt(3), 32'h4);
    wr(GETOT_PWR_OFF, 32'h1);
    chk({31'h0, tot_power}, 32'h1);
  endtask
  task t_scan;
    wr(GETOT_SCAN_OFF, 32'h3);
    @(posedge ref_clk);
    scan_req <= 1;
    for (int k = 0; k < 10 && scan_done !== 1'b1; k++) @(posedge ref_clk);
    scan_req <= 0;
    chk({31'h0, scan_done}, 32'h1);
    chk(scan_data, 32'h4);
    rdc(GETOT_SRES_OFF, 32'h4);
  endtask
  task t_bad;
    wr(8'h40, 32'h5);
    chk({30'h0, rr}, {30'h0, GETOT_RESP_SLVERR});
    rdc(8'h40, 32'h0);
    chk({30'h0, rr}, {30'h0, GETOT_RESP_SLVERR});
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 0;
    t_reset;
    t_count;
    t_edge;
    t_wr;
    t_rdclr;
    t_gate;
    t_pwr;
    t_scan;
    t_bad;
    stop_test;
  end
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
endmodule
